// ---- core/csh_consts.svh ----
`ifndef CSH_CONSTS_SVH
`define CSH_CONSTS_SVH
`define CSH_SAMPLE_W      16
`define CSH_RESULT_W      24
`define CSH_PIN_RESULT_W  12
`define CSH_CLK_PERIOD_NS 4
`define CSH_MIN_CYCLE_NS  100
`define CSH_MIN_CYCLE_CYC \
  ((`CSH_MIN_CYCLE_NS + `CSH_CLK_PERIOD_NS - 1) / `CSH_CLK_PERIOD_NS)
`define CSH_RESULT_LAT    3
`define CSH_FIFO_DEPTH    16
`endif

// ---- core/csh_pkg.sv ----
package csh_pkg;
  typedef enum logic [1:0] {
    CSH_IDLE,
    CSH_RUN,
    CSH_OUT_LO,
    CSH_OUT_HI
  } csh_state_t;
endpackage

// ---- core/csh_fifo.sv ----
`include "csh_consts.svh"
module csh_fifo #(
  parameter int WIDTH = `CSH_SAMPLE_W,
  parameter int DEPTH = `CSH_FIFO_DEPTH
) (
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("csh_fifo depth must be a power of two, at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  assign next_wr_ptr = wr_ptr + (AW+1)'(push);
  assign next_rd_ptr = rd_ptr + (AW+1)'(pop);
  assign out_valid_o = wr_ptr != rd_ptr;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
  // ready is registered from the next pointers, so it leaves a flip-flop
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      in_ready_o <= 1'b1;
    end else begin
      wr_ptr     <= next_wr_ptr;
      rd_ptr     <= next_rd_ptr;
      in_ready_o <= (next_wr_ptr - next_rd_ptr) != (AW+1)'(DEPTH);
    end
  end
endmodule

// ---- core/csh_port.sv ----
`include "csh_consts.svh"
// Notes on behaviour
// - sample comes from register write or 16 pins, chosen by configuration
// - result read as low/high words or as two 12-bit pin words
// - result register words are safe to read after result ready rises; the pin low word comes the cycle before
// - master drives start; host writes next sample after start falls
// - a master never takes samples from the parallel pins
// - start pulses faster than the maximum sample rate are ignored
// - a correctly timed start resynchronises the cycle immediately
module csh_port #(
  parameter int MIN_CYCLE = `CSH_MIN_CYCLE_CYC,
  parameter int RES_LAT   = `CSH_RESULT_LAT
) (
  input  wire logic                          mclk_i,
  input  wire logic                          reset_i,
  input  wire logic                          master_mode_i,
  input  wire logic                          pin_input_sel_i,
  input  wire logic                          sample_wr_i,
  input  wire logic [`CSH_SAMPLE_W-1:0]      sample_wr_data_i,
  output logic                               sample_wr_ready_o,
  input  wire logic [`CSH_SAMPLE_W-1:0]      parallel_sample_inputs_i,
  input  wire logic                          start_i,
  output logic                               start_o,
  output logic                               start_oe_o,
  output logic [`CSH_SAMPLE_W-1:0]           core_sample_o,
  output logic                               core_sample_valid_o,
  input  wire logic [`CSH_RESULT_W-1:0]      core_result_i,
  output logic [`CSH_PIN_RESULT_W-1:0]       result_low_word_register_o,
  output logic [`CSH_PIN_RESULT_W-1:0]       result_high_word_register_o,
  output logic [`CSH_PIN_RESULT_W-1:0]       parallel_result_outputs_o,
  output logic                               result_ready_strobe_o,
  output logic                               result_busy_o
);
  initial begin
    if (MIN_CYCLE < 2 || MIN_CYCLE > 255 || RES_LAT < 1 || RES_LAT > 15)
      $error("csh_port counts out of range");
  end
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [`CSH_SAMPLE_W-1:0] pin_s1, pin_s2;
  logic                     go_s1, go_s2;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      go_s1  <= 1'b0;
      go_s2  <= 1'b0;
    end else begin
      pin_s1 <= parallel_sample_inputs_i;
      pin_s2 <= pin_s1;
      go_s1  <= start_i;
      go_s2  <= go_s1;
    end
  end
  // ----------------------------------------------------------------
  // register-written samples, buffered
  // ----------------------------------------------------------------
  // the fifo lets the host run ahead of the cycle; its ready is back-pressure
  logic [`CSH_SAMPLE_W-1:0] fifo_data;
  logic                     fifo_valid;
  logic                     fifo_pop;
  csh_fifo #(.WIDTH(`CSH_SAMPLE_W), .DEPTH(`CSH_FIFO_DEPTH)) u_fifo (
    .mclk_i      (mclk_i),
    .reset_i     (reset_i),
    .in_data_i   (sample_wr_data_i),
    .in_valid_i  (sample_wr_i),
    .in_ready_o  (sample_wr_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );
  // ----------------------------------------------------------------
  // cycle sequencing
  // ----------------------------------------------------------------
  csh_pkg::csh_state_t state;
  logic [7:0]          cyc_cnt;
  logic [3:0]          lat_cnt;
  logic                use_pins;
  logic                ext_go;
  logic                master_go;
  logic                cyc_start;
  assign use_pins  = pin_input_sel_i && !master_mode_i;
  // level, not edge: a start held high repeats at the minimum period
  assign ext_go    = go_s2;
  assign master_go = master_mode_i && fifo_valid;
  // pulses inside the minimum period are simply dropped
  assign cyc_start = (cyc_cnt == 8'h00) &&
                     (master_mode_i ? master_go : ext_go);
  assign fifo_pop  = cyc_start && !use_pins;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cyc_cnt <= 8'h00;
    end else if (cyc_start) begin
      cyc_cnt <= 8'(MIN_CYCLE - 1);
    end else if (cyc_cnt != 8'h00) begin
      cyc_cnt <= cyc_cnt - 8'h01;
    end
  end
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      core_sample_o       <= '0;
      core_sample_valid_o <= 1'b0;
    end else begin
      core_sample_valid_o <= cyc_start;
      if (cyc_start) begin
        core_sample_o <= use_pins ? pin_s2 : fifo_data;
      end
    end
  end
  // master start: high one cycle; falling edge says next write is safe
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      start_o    <= 1'b0;
      start_oe_o <= 1'b0;
    end else begin
      start_o    <= cyc_start && master_mode_i;
      start_oe_o <= master_mode_i;
    end
  end
  // ----------------------------------------------------------------
  // result output
  // ----------------------------------------------------------------
  logic [`CSH_RESULT_W-1:0] res_hold;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state                       <= csh_pkg::CSH_IDLE;
      lat_cnt                     <= 4'h0;
      res_hold                    <= '0;
      result_low_word_register_o  <= '0;
      result_high_word_register_o <= '0;
      parallel_result_outputs_o   <= '0;
      result_ready_strobe_o       <= 1'b0;
      result_busy_o               <= 1'b0;
    end else begin
      case (state)
        csh_pkg::CSH_IDLE: begin
          result_ready_strobe_o <= 1'b0;
          if (cyc_start) begin
            lat_cnt <= 4'(RES_LAT - 1);
            state   <= csh_pkg::CSH_RUN;
          end
        end
        csh_pkg::CSH_RUN: begin
          if (cyc_start) begin
            lat_cnt <= 4'(RES_LAT - 1);
          end else if (lat_cnt == 4'h0) begin
            res_hold      <= core_result_i;
            result_busy_o <= 1'b1;
            state         <= csh_pkg::CSH_OUT_LO;
          end else begin
            lat_cnt <= lat_cnt - 4'h1;
          end
        end
        csh_pkg::CSH_OUT_LO: begin
          result_low_word_register_o  <= res_hold[11:0];
          result_high_word_register_o <= res_hold[23:12];
          parallel_result_outputs_o   <= res_hold[11:0];
          state                       <= csh_pkg::CSH_OUT_HI;
        end
        default: begin
          parallel_result_outputs_o <= res_hold[23:12];
          result_ready_strobe_o     <= 1'b1;
          result_busy_o             <= 1'b0;
          state                     <= cyc_start ? csh_pkg::CSH_RUN
                                                 : csh_pkg::CSH_IDLE;
          if (cyc_start) lat_cnt <= 4'(RES_LAT - 1);
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  int unsigned gap_cnt;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) gap_cnt <= 0;
    else if (cyc_start) gap_cnt <= 1;
    else if (gap_cnt != 0) gap_cnt <= gap_cnt + 1;
  end
  a_start_spacing: assert property (@(posedge mclk_i) disable iff (reset_i)
    cyc_start && gap_cnt != 0 |-> gap_cnt >= MIN_CYCLE)
    else $error("cycle started inside the minimum period");
  a_master_no_pins: assert property (@(posedge mclk_i) disable iff (reset_i)
    master_mode_i && cyc_start |=> core_sample_valid_o &&
    core_sample_o == $past(fifo_data))
    else $error("master took a sample not from the register");
  a_pin_sample: assert property (@(posedge mclk_i) disable iff (reset_i)
    use_pins && cyc_start |=> core_sample_o == $past(pin_s2))
    else $error("pin sample not captured");
  a_start_pulse: assert property (@(posedge mclk_i) disable iff (reset_i)
    start_o |=> !start_o)
    else $error("master start held longer than one cycle");
  a_ext_resync: assert property (@(posedge mclk_i) disable iff (reset_i)
    !master_mode_i && ext_go && cyc_cnt == 8'h00 |=> core_sample_valid_o)
    else $error("correctly timed start not taken");
  sequence s_busy_end;
    result_busy_o ##1 !result_busy_o;
  endsequence
  a_ready_after_busy: assert property (@(posedge mclk_i)
    disable iff (reset_i) s_busy_end |-> result_ready_strobe_o)
    else $error("ready not raised when update ends");
  a_words_split: assert property (@(posedge mclk_i) disable iff (reset_i)
    $rose(result_ready_strobe_o) |->
    parallel_result_outputs_o == result_high_word_register_o)
    else $error("pin high word mismatch");
  a_pop_on_start: assert property (@(posedge mclk_i) disable iff (reset_i)
    fifo_pop |=> sample_wr_ready_o)
    else $error("sample buffer still full after a sample was taken");
endmodule

// ---- dv/csh_core_model.sv ----
`include "csh_consts.svh"
// ------------------------------------------
// filter core stand-in: result from sample
// ------------------------------------------
module csh_core_model (
  input  wire logic                     mclk_i,
  input  wire logic                     reset_i,
  input  wire logic [`CSH_SAMPLE_W-1:0] sample_i,
  input  wire logic                     valid_i,
  output logic      [`CSH_RESULT_W-1:0] result_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // halves differ so a swapped word order shows
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      result_o <= 24'h000000;
    end else if (valid_i) begin
      result_o <= {sample_i[11:0], ~sample_i[11:0]};
    end
  end
endmodule

// ---- dv/cascade_sample_handshake_tb_top.sv ----
`include "csh_consts.svh"
module cascade_sample_handshake_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i, reset_i, mst, psel, wr, rdy, st, st_o, st_oe;
  logic        cv, rr, busy, full;
  logic [15:0] wd, pins, cs;
  logic [23:0] res;
  logic [11:0] lo, hi, po, prev;
  int          error_cnt, checked, cyc;
  csh_port i_csh_port (.mclk_i, .reset_i, .master_mode_i(mst),
    .pin_input_sel_i(psel), .sample_wr_i(wr), .sample_wr_data_i(wd),
    .sample_wr_ready_o(rdy), .parallel_sample_inputs_i(pins),
    .start_i(st), .start_o(st_o), .start_oe_o(st_oe),
    .core_sample_o(cs), .core_sample_valid_o(cv), .core_result_i(res),
    .result_low_word_register_o(lo), .result_high_word_register_o(hi),
    .parallel_result_outputs_o(po), .result_ready_strobe_o(rr),
    .result_busy_o(busy));
  csh_core_model i_csh_core_model (.mclk_i, .reset_i, .sample_i(cs),
    .valid_i(cv), .result_o(res));
  // ------------------------------------------
  // clock, timeout, helpers
  // ------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic wait_cv(input int n);
    for (int i = 0; i < n && cv !== 1'b1; i++) @(negedge mclk_i);
  endtask
  task automatic write(input logic [15:0] d);
    for (int i = 0; i < 40 && rdy !== 1'b1; i++) @(negedge mclk_i);
    wr = 1'b1;
    wd = d;
    @(negedge mclk_i);
    wr = 1'b0;
  endtask
  // external start from support logic; pins held past its fall
  task automatic pulse_start(input logic [15:0] d);
    @(negedge mclk_i);
    pins = d;
    st = 1'b1;
    repeat (2) @(negedge mclk_i);
    st = 1'b0;
    wait_cv(8);
  endtask
  // ------------------------------------------
  // scenarios
  // ------------------------------------------
  task automatic t_master();
    mst = 1'b1;
    psel = 1'b1;
    pins = 16'h0F0F;
    write(16'h1234);
    wait_cv(40);
    chk(cs, 16'h1234);
    chk(st_o, 1'b1);
    chk(st_oe, 1'b1);
    for (int i = 0; i < 20 && rr !== 1'b1; i++) begin
      prev = po;
      @(negedge mclk_i);
    end
    chk(prev, 12'hDCB);
    chk(po, 12'h234);
    chk({hi, lo}, 24'h234DCB);
    chk(busy, 1'b0);
  endtask
  task automatic t_slave();
    int n;
    repeat (30) @(negedge mclk_i);
    mst = 1'b0;
    pulse_start(16'hBEEF);
    chk(cs, 16'hBEEF);
    @(negedge mclk_i);
    pulse_start(16'h1111);
    n = 0;
    repeat (30) begin
      @(negedge mclk_i);
      if (cv === 1'b1) n++;
    end
    chk(24'(n), 24'h0);
    pulse_start(16'h2222);
    chk(cs, 16'h2222);
  endtask
  // start held high: cycles repeat at the minimum period, pins kept still
  task automatic t_held();
    int n;
    @(negedge mclk_i);
    pins = 16'h5A5A;
    st = 1'b1;
    n = 0;
    repeat (80) begin
      @(negedge mclk_i);
      if (cv === 1'b1) n++;
    end
    st = 1'b0;
    chk(24'(n), 24'h3);
    chk(cs, 16'h5A5A);
  endtask
  task automatic t_fifo();
    logic [15:0] q[$];
    int          n;
    repeat (30) @(negedge mclk_i);
    mst = 1'b0;
    psel = 1'b0;
    full = 1'b0;
    for (int i = 0; i < 24; i++) begin
      @(negedge mclk_i);
      wr = (rdy === 1'b1);
      wd = 16'h0100 + 16'(i);
      if (rdy === 1'b1) q.push_back(wd);
      else full = 1'b1;
    end
    @(negedge mclk_i);
    wr = 1'b0;
    mst = 1'b1;
    chk(full, 1'b1);
    chk(24'(q.size()), 24'h10);
    while (q.size() > 0) begin
      wait_cv(40);
      chk(cs, q.pop_front());
      @(negedge mclk_i);
    end
    n = 0;
    repeat (60) begin
      @(negedge mclk_i);
      if (cv === 1'b1) n++;
    end
    chk(24'(n), 24'h0);
  endtask
  initial begin
    {mst, psel, wr, st, full} = 5'h00;
    wd = 16'h0000;
    pins = 16'h0000;
    reset_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    reset_i = 1'b0;
    chk({rr, cv, st_o, st_oe, busy}, 24'h0);
    t_master();
    t_slave();
    t_held();
    t_fifo();
    print_verdict();
  end
endmodule
